/* File: hw/icc_cfg_mem.sv */
// Writable configuration memory with two registered read ports
`timescale 1ns/1ns
module icc_cfg_mem
  import icc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [CFG_AW-1:0] wr_idx_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [CFG_AW-1:0] a_idx_i,
  output logic [DATA_W-1:0] a_data_o,
  input wire logic [CFG_AW-1:0] b_idx_i,
  output logic [DATA_W-1:0] b_data_o
);

  icc_mem_type s;
  icc_mem_type next_s;

  always_comb begin
    next_s = s;
    if (wr_en_i) begin
      next_s.words[wr_idx_i] = wr_data_i;
    end
    // Port B feeds the checker, port A the host
    next_s.a_data = s.words[a_idx_i];
    next_s.b_data = s.words[b_idx_i];
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Word 0 sits at the low end of the packed array
      s.words <= {{(CFG_WORDS - 1){CFG_RESET}}, CFG0_RESET};
      s.a_data <= '0;
      s.b_data <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign a_data_o = s.a_data;
  assign b_data_o = s.b_data;

endmodule

/* File: hw/icc_core.sv */
// Integrity checks (serial checksum, memory map CRC, ROM CRC) and clock counter
// Functional notes
// - Serial checksum check ignored when its enable is 0, applied when 1.
// - Enabled checksum check flags the interface error on a bad write.
// - Enable bit 1 turns on memory map CRC; mismatch sets its error flag.
// - Memory map CRC covers all writable registers, never read-only ones.
// - Memory map CRC recomputed and compared every 426.6 us while enabled.
// - Reference rebuilt after writes, calibration, sequence end, readout exit.
// - ROM check always runs at power-up; bit 0 only gates its error flag.
// - Clock counter is 8-bit read-only at 0x08, reset 0x00.
// - Counter advances once per 131 master clock pulses at 76.8 kHz.
// - Counter wraps from its maximum back to zero and continues.
// - Counter runs only while its enable bit is set by the host.
`timescale 1ns/1ns
module icc_core
  import icc_pkg::*;
#(
  parameter int unsigned CHECK_PERIOD_CYCLES = CHECK_PERIOD_CYC,
  parameter logic [7:0] ROM_CRC_EXPECTED = 8'h5a
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire icc_wr_type wr_i,
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic rd_valid_o,
  output logic [DATA_W-1:0] rd_data_o,
  input wire icc_event_type event_i,
  input wire logic [1:0] err_clear_i,
  output logic [ROM_AW-1:0] rom_addr_o,
  input wire logic [DATA_W-1:0] rom_data_i,
  output icc_err_type err_o,
  output logic scan_busy_o
);

  // ----------------------------------------
  // State and memory
  // ----------------------------------------
  localparam logic [15:0] PERIOD_LAST = 16'(CHECK_PERIOD_CYCLES - 1);

  icc_core_type s;
  icc_core_type next_s;
  logic [DATA_W-1:0] mem_a_data;
  logic [DATA_W-1:0] mem_b_data;
  logic wr_take;
  logic wr_cfg;
  logic recalc;
  logic period_tick;
  logic [7:0] crc_step;
  logic [7:0] crc_final;

  assign wr_take = wr_i.en && (wr_i.crc_ok || !s.enables[EN_SPI_BIT]);
  assign wr_cfg = wr_take && icc_cfg_hit(wr_i.addr);
  assign recalc = (wr_take && (wr_cfg || wr_i.addr == ERROR_EN_ADDR)) || event_i.calibration_done
                  || event_i.single_seq_idle || event_i.continuous_readout_clear;
  assign period_tick = s.timer == PERIOD_LAST;

  icc_cfg_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_cfg),
    .wr_idx_i(icc_cfg_index(wr_i.addr)),
    .wr_data_i(wr_i.data),
    .a_idx_i(icc_cfg_index(rd_addr_i)),
    .a_data_o(mem_a_data),
    .b_idx_i(s.step[CFG_AW-1:0]),
    .b_data_o(mem_b_data)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    crc_step = icc_crc8_word(s.crc, (s.st == ST_ROM) ? rom_data_i : mem_b_data);
    // Enables are writable, so they close the sum
    crc_final = icc_crc8_word(crc_step, s.enables);

    // Host register writes; counter address is read-only and ignored
    if (wr_take && wr_i.addr == ERROR_EN_ADDR) begin
      next_s.enables = wr_i.data;
    end

    // Bad checksum flag, set beats clear
    if (err_clear_i[CLR_SPI_BIT]) begin
      next_s.spi_err = 1'b0;
    end
    if (wr_i.en && !wr_i.crc_ok && s.enables[EN_SPI_BIT]) begin
      next_s.spi_err = 1'b1;
    end
    if (err_clear_i[CLR_MM_BIT]) begin
      next_s.mm_err = 1'b0;
    end

    // Period timer runs only while the check is on
    if (!s.enables[EN_MM_BIT] || period_tick) begin
      next_s.timer = '0;
    end else begin
      next_s.timer = s.timer + 16'h0001;
    end

    if (recalc) begin
      next_s.ref_pending = 1'b1;
    end

    unique case (s.st)
      // ROM walk always runs after reset
      ST_ROM: begin
        next_s.step = s.step + 7'h01;
        if (s.step != STEP_ZERO) begin
          next_s.crc = crc_step;
        end
        if (s.step == ROM_STEP_LAST) begin
          next_s.rom_fail = crc_step != ROM_CRC_EXPECTED;
          next_s.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        next_s.step = STEP_ZERO;
        next_s.crc = CRC_INIT;
        // Pending rebuild starts at once, ahead of any compare
        if (s.enables[EN_MM_BIT] && (s.ref_pending || recalc || period_tick)) begin
          next_s.st = ST_MM;
          next_s.building = s.ref_pending || recalc;
          next_s.ref_pending = 1'b0;
        end
      end
      ST_MM: begin
        next_s.step = s.step + 7'h01;
        if (s.step != STEP_ZERO) begin
          next_s.crc = crc_step;
        end
        if (!s.enables[EN_MM_BIT]) begin
          // Abandoned rebuild must rerun when re-enabled
          next_s.ref_pending = s.ref_pending || s.building || recalc;
          next_s.st = ST_IDLE;
        end else if (recalc) begin
          // Mid-scan change restarts as a rebuild
          next_s.step = STEP_ZERO;
          next_s.crc = CRC_INIT;
          next_s.building = 1'b1;
          next_s.ref_pending = 1'b0;
        end else if (s.step == CFG_STEP_LAST) begin
          next_s.st = ST_IDLE;
          if (s.building) begin
            next_s.ref_crc = crc_final;
          end else if (crc_final != s.ref_crc) begin
            next_s.mm_err = 1'b1;
          end
        end
      end
    endcase

    // Master clock enable from the reference clock
    // Cleared while disabled, so the first count lands a fixed time after enable
    if (!s.enables[EN_CNT_BIT] || s.mclk_div == MCLK_DIV_LAST) begin
      next_s.mclk_div = '0;
    end else begin
      next_s.mclk_div = s.mclk_div + 9'h001;
    end
    // Prescaler cleared while disabled, count frozen
    if (!s.enables[EN_CNT_BIT]) begin
      next_s.mclk_pulses = '0;
    end else if (s.mclk_div == MCLK_DIV_LAST) begin
      if (s.mclk_pulses == MCLK_PULSE_LAST) begin
        next_s.mclk_pulses = '0;
        next_s.count = s.count + 8'h01;
      end else begin
        next_s.mclk_pulses = s.mclk_pulses + 8'h01;
      end
    end

    // Register reads, one cycle latency, unmapped read as zero
    next_s.rd_valid = rd_en_i;
    next_s.rd_mem = rd_en_i && icc_cfg_hit(rd_addr_i);
    next_s.rd_reg = '0;
    if (rd_addr_i == ERROR_EN_ADDR) begin
      next_s.rd_reg = s.enables;
    end else if (rd_addr_i == CLK_COUNT_ADDR) begin
      next_s.rd_reg = {16'h0000, s.count};
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s.st <= ST_ROM;
      s.step <= STEP_ZERO;
      s.crc <= CRC_INIT;
      s.ref_crc <= CRC_INIT;
      s.building <= 1'b0;
      // First enabled scan must build a reference
      s.ref_pending <= 1'b1;
      s.timer <= '0;
      s.enables <= ERROR_EN_RESET;
      s.mclk_div <= '0;
      s.mclk_pulses <= '0;
      s.count <= CLK_COUNT_RESET;
      s.rom_fail <= 1'b0;
      s.mm_err <= 1'b0;
      s.spi_err <= 1'b0;
      s.rd_valid <= 1'b0;
      s.rd_mem <= 1'b0;
      s.rd_reg <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_valid_o = s.rd_valid;
  assign rd_data_o = s.rd_mem ? mem_a_data : s.rd_reg;
  assign rom_addr_o = s.step[ROM_AW-1:0];
  assign scan_busy_o = s.st != ST_IDLE;
  // Reporting only, check result kept regardless
  assign err_o.rom_crc_error = s.rom_fail && s.enables[EN_ROM_BIT];
  assign err_o.config_memory_check_error = s.mm_err;
  assign err_o.spi_crc_error = s.spi_err;

endmodule

/* File: hw/icc_pkg.sv */
// Shared constants, types and helpers for the integrity checks and clock counter
package icc_pkg;

  // ----------------------------------------
  // Clocking and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned MCLK_HZ = 76_800;
  localparam logic [8:0] MCLK_DIV_LAST = 9'(CLK_HZ / MCLK_HZ - 1);
  localparam int unsigned MCLK_PER_COUNT = 131;
  localparam logic [7:0] MCLK_PULSE_LAST = 8'(MCLK_PER_COUNT - 1);
  localparam int unsigned CHECK_PERIOD_NS = 426_600;
  // Longest time, so round down
  localparam int unsigned CHECK_PERIOD_CYC = CHECK_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 24;
  localparam logic [7:0] ERROR_EN_ADDR = 8'h07;
  localparam logic [7:0] CLK_COUNT_ADDR = 8'h08;
  localparam logic [7:0] CFG_BASE_ADDR = 8'h09;
  localparam int unsigned CFG_WORDS = 16;
  localparam int unsigned CFG_AW = 4;
  localparam logic [23:0] CFG_RESET = 24'h000100;
  localparam logic [23:0] CFG0_RESET = 24'h800100;
  localparam logic [23:0] ERROR_EN_RESET = 24'h000000;
  localparam logic [7:0] CLK_COUNT_RESET = 8'h00;

  // Enable bit positions in error_check_enables
  localparam int unsigned EN_ROM_BIT = 0;
  localparam int unsigned EN_MM_BIT = 1;
  localparam int unsigned EN_SPI_BIT = 2;
  localparam int unsigned EN_CNT_BIT = 3;

  // Error clear mask positions
  localparam int unsigned CLR_MM_BIT = 0;
  localparam int unsigned CLR_SPI_BIT = 1;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  localparam int unsigned ROM_WORDS = 32;
  localparam int unsigned ROM_AW = 5;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [6:0] STEP_ZERO = 7'h00;
  localparam logic [6:0] CFG_STEP_LAST = 7'(CFG_WORDS);
  localparam logic [6:0] ROM_STEP_LAST = 7'(ROM_WORDS);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_ROM,
    ST_IDLE,
    ST_MM
  } icc_state_type;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic crc_ok;
  } icc_wr_type;

  typedef struct packed {
    logic calibration_done;
    logic single_seq_idle;
    logic continuous_readout_clear;
  } icc_event_type;

  typedef struct packed {
    logic rom_crc_error;
    logic config_memory_check_error;
    logic spi_crc_error;
  } icc_err_type;

  typedef struct packed {
    icc_state_type st;
    logic [6:0] step;
    logic [7:0] crc;
    logic [7:0] ref_crc;
    logic building;
    logic ref_pending;
    logic [15:0] timer;
    logic [DATA_W-1:0] enables;
    logic [8:0] mclk_div;
    logic [7:0] mclk_pulses;
    logic [7:0] count;
    logic rom_fail;
    logic mm_err;
    logic spi_err;
    logic rd_valid;
    logic rd_mem;
    logic [DATA_W-1:0] rd_reg;
  } icc_core_type;

  typedef struct packed {
    logic [CFG_WORDS-1:0][DATA_W-1:0] words;
    logic [DATA_W-1:0] a_data;
    logic [DATA_W-1:0] b_data;
  } icc_mem_type;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] icc_crc8_word(input logic [7:0] crc_in, input logic [DATA_W-1:0] word);
    logic [7:0] c;
    c = crc_in;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (c[7] ^ word[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  function automatic logic icc_cfg_hit(input logic [ADDR_W-1:0] addr);
    return (addr >= CFG_BASE_ADDR) && (addr < CFG_BASE_ADDR + 8'(CFG_WORDS));
  endfunction

  function automatic logic [CFG_AW-1:0] icc_cfg_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] d;
    d = addr - CFG_BASE_ADDR;
    return d[CFG_AW-1:0];
  endfunction

endpackage

/* File: verif/icc_core_props.sv */
// Port-level assertions for the integrity checks core
`timescale 1ns/1ns
module icc_core_props
  import icc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire icc_wr_type wr_i,
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  input wire logic rd_valid_o,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic [1:0] err_clear_i,
  input wire icc_err_type err_o,
  input wire logic scan_busy_o
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Clear with no bad write in the same cycle, since a set beats a clear
  sequence spi_clear;
    err_clear_i[1] && !(wr_i.en && !wr_i.crc_ok);
  endsequence
  // Walk is short; a longer one means the ROM pass never finished
  sequence rom_walk;
    scan_busy_o ##[1:40] !scan_busy_o;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_RD_ANSWER: assert property (rd_en_i |=> rd_valid_o)
    else $error("read not answered");
  AST_RD_CAUSE: assert property (rd_valid_o |-> $past(rd_en_i))
    else $error("answer without read");
  AST_CNT_WIDTH: assert property (rd_valid_o && $past(rd_addr_i) == CLK_COUNT_ADDR |-> rd_data_o[23:8] == 16'h0000)
    else $error("counter upper bits set");
  AST_UNMAPPED: assert property (rd_valid_o && $past(rd_addr_i) > 8'h18 |-> rd_data_o == 24'h000000)
    else $error("unmapped read not zero");
  AST_GOOD_WR: assert property (wr_i.en && wr_i.crc_ok && !err_o.spi_crc_error |=> !err_o.spi_crc_error)
    else $error("good write raised checksum flag");
  AST_SPI_CAUSE: assert property ($rose(err_o.spi_crc_error) |-> $past(wr_i.en && !wr_i.crc_ok))
    else $error("checksum flag without bad write");
  AST_SPI_CLR: assert property (spi_clear |=> !err_o.spi_crc_error)
    else $error("checksum flag not cleared");
  AST_ROM_WALK: assert property ($fell(rst_i) |-> rom_walk)
    else $error("power-up ROM walk missing");
  AST_ROM_GATE: assert property ($changed(err_o.rom_crc_error) |-> $past(wr_i.en) || $past(wr_i.en, 2))
    else $error("ROM flag moved without enable write");
endmodule

bind icc_core icc_core_props u_props (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .wr_i(wr_i),
  .rd_en_i(rd_en_i),
  .rd_addr_i(rd_addr_i),
  .rd_valid_o(rd_valid_o),
  .rd_data_o(rd_data_o),
  .err_clear_i(err_clear_i),
  .err_o(err_o),
  .scan_busy_o(scan_busy_o)
);

/* File: verif/icc_rom_model.sv */
// Behavioural ROM facing the core's ROM walk
`timescale 1ns/1ns
module icc_rom_model
  import icc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [ROM_AW-1:0] rom_addr_i,
  output logic [DATA_W-1:0] rom_data_o
);
  // ----------------------------------------
  // Contents
  // ----------------------------------------
  // One cycle of latency, as the core expects; pattern keeps words distinct
  always_ff @(posedge ref_clk_i) begin
    rom_data_o <= {8'h3c, 11'h000, rom_addr_i};
  end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the integrity checks core
`timescale 1ns/1ns
module testbench
  import icc_pkg::*;
;
  logic clk, rst, rd_en, rd_valid, busy;
  logic [7:0] rd_addr;
  logic [23:0] rd_data, rom_data, got;
  logic [4:0] rom_addr;
  logic [1:0] clr;
  icc_wr_type wr;
  icc_event_type ev;
  icc_err_type err;
  int failures, num_checks, cycles;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  icc_core #(.CHECK_PERIOD_CYCLES(40)) dut (.ref_clk_i(clk), .rst_i(rst), .wr_i(wr), .rd_en_i(rd_en),
    .rd_addr_i(rd_addr), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .event_i(ev), .err_clear_i(clr),
    .rom_addr_o(rom_addr), .rom_data_i(rom_data), .err_o(err), .scan_busy_o(busy));
  icc_rom_model u_rom (.ref_clk_i(clk), .rom_addr_i(rom_addr), .rom_data_o(rom_data));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      failures++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] d, input logic ok);
    @(negedge clk) wr = '{en: 1'b1, addr: a, data: d, crc_ok: ok};
    @(negedge clk) wr.en = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [23:0] e);
    got = 24'hxxxxxx;
    @(negedge clk) rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk) rd_en = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (rd_valid === 1'b1) begin
        got = rd_data;
        break;
      end
      @(negedge clk);
    end
    chk(got, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Own reckoning of the power-up ROM signature
  function automatic logic [7:0] rom_crc();
    logic [7:0] c;
    logic [23:0] w;
    c = 8'hff;
    for (int k = 0; k < 32; k++) begin
      w = {8'h3c, 11'h000, 5'(k)};
      for (int i = 23; i >= 0; i--) begin
        c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Two counter periods plus margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    rd_en = 1'b0;
    rd_addr = 8'h00;
    clr = 2'b00;
    wr = '0;
    ev = '0;
    wait_cyc(4);
    rst = 1'b0;
    wait_cyc(50);
    chk({21'h0, err}, 24'h000000);
    rchk(8'h08, 24'h000000);
    rchk(8'h07, 24'h000000);
    rchk(8'hff, 24'h000000);
    rchk(8'h09, 24'h800100);
    wr_reg(8'h08, 24'h0000aa, 1'b1);
    rchk(8'h08, 24'h000000);
    wr_reg(8'h0a, 24'h00abcd, 1'b0);
    rchk(8'h0a, 24'h00abcd);
    chk({23'h0, err.spi_crc_error}, 24'h000000);
    wr_reg(8'h07, 24'h000004, 1'b1);
    wr_reg(8'h0b, 24'h001234, 1'b0);
    chk({23'h0, err.spi_crc_error}, 24'h000001);
    rchk(8'h0b, 24'h000100);
    @(negedge clk) clr = 2'b10;
    @(negedge clk) clr = 2'b00;
    chk({23'h0, err.spi_crc_error}, 24'h000000);
    wr_reg(8'h07, 24'h000003, 1'b1);
    wait_cyc(3);
    chk({23'h0, err.rom_crc_error}, {23'h0, rom_crc() != 8'h5a});
    wait_cyc(200);
    chk({23'h0, err.config_memory_check_error}, 24'h000000);
    wr_reg(8'h0c, 24'h00f00f, 1'b1);
    chk({23'h0, busy}, 24'h000001);
    wait_cyc(100);
    chk({23'h0, err.config_memory_check_error}, 24'h000000);
    for (int k = 0; k < 3; k++) begin
      @(negedge clk) ev = icc_event_type'(3'b001 << k);
      @(negedge clk) ev = '0;
      wait_cyc(100);
      chk({23'h0, err.config_memory_check_error}, 24'h000000);
    end
    // Host enables the counter before use
    wr_reg(8'h07, 24'h00000a, 1'b1);
    wait_cyc(3);
    chk({23'h0, err.rom_crc_error}, 24'h000000);
    wait_cyc(33990);
    rchk(8'h08, 24'h000000);
    wait_cyc(110);
    rchk(8'h08, 24'h000001);
    chk({23'h0, err.config_memory_check_error}, 24'h000000);
    wr_reg(8'h07, 24'h000002, 1'b1);
    wait_cyc(34100);
    rchk(8'h08, 24'h000001);
    end_of_test();
  end
endmodule
